// ==== rapl_bank.sv ====
// peripheral register bank with alias pair and access kinds
//
// Overview of operation
// - read-only bits ignore writes, read state
// - write-only bits accept writes, read undefined
// - reserved bits always read as zero
// - reset values load; debug survives soft reset
// - base and aliases read same storage
// - clear alias ones clear stored bits
// - set alias ones set stored bits
// - toggle alias ones invert stored bits
// - field high index down to low
//
// offset map of the peripheral window
//   0 base word, read and written whole
//   1 set view of the base word, ones set
//   2 clear view of the base word, ones clear
//   3 toggle view of the base word, ones invert
//   4 control, bits 7:6 reserved, mode in 5:2
//   5 status, read only, follows hw_status
//   6 command, write only, bits 3:0 pulse once
//   7 debug control, bit 0 only, kept by soft reset
`timescale 1ns/1ns
module rapl_bank #(
  parameter int unsigned data_w = rapl_pkg::data_w
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic [rapl_pkg::addr_w-1:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [data_w-1:0] wdata,
  input wire logic [data_w-1:0] hw_status,
  output logic [data_w-1:0] rdata,
  output logic [data_w-1:0] pair_value,
  output logic [3:0] mode,
  output logic [3:0] cmd_pulse,
  output logic debug_hold
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] debug;
    logic [7:0] cmd;
    logic [7:0] rdata;
  } rapl_bank_s;

  rapl_bank_s state;
  rapl_bank_s next_state;
  logic [data_w-1:0] store_value;
  // write strobes towards the shared word, one per view
  logic wr_live;
  logic wr_hit_base;
  logic wr_hit_set;
  logic wr_hit_clear;
  logic wr_hit_toggle;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the field map and masks are laid out for an 8-bit word only
  if (data_w != 8)
  begin : g_bad_width
    $error("rapl_bank serves 8-bit data only");
  end
  // the mode field must sit inside the word, high index over low
  if (rapl_pkg::mode_hi >= data_w || rapl_pkg::mode_lo > rapl_pkg::mode_hi)
  begin : g_bad_field
    $error("rapl_bank mode field outside the word");
  end
  // the mode port is fixed at four bits, so the field span must match it
  if (rapl_pkg::mode_hi - rapl_pkg::mode_lo + 1 != 4)
  begin : g_bad_mode
    $error("rapl_bank mode field must span four bits");
  end
  // reset values must not set reserved bits, or they would read back
  if ((rapl_pkg::ctrl_reset & ~rapl_pkg::ctrl_mask) != rapl_pkg::zero)
  begin : g_bad_ctrl
    $error("rapl_bank ctrl reset touches reserved bits");
  end
  if ((rapl_pkg::debug_reset & ~rapl_pkg::debug_mask) != rapl_pkg::zero)
  begin : g_bad_debug
    $error("rapl_bank debug reset touches reserved bits");
  end
  if ((rapl_pkg::cmd_reset & ~rapl_pkg::cmd_mask) != rapl_pkg::zero)
  begin : g_bad_cmd
    $error("rapl_bank cmd reset touches reserved bits");
  end

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off, input logic en);
    hit = en && (a == off);
  endfunction

  // keeps only the implemented bits of a word, reserved ones read zero
  function automatic logic [7:0] keep(input logic [7:0] d, input logic [7:0] m);
    keep = d & m;
  endfunction

  // ----------------------------------------
  // write qualifiers
  // ----------------------------------------
  // soft reset owns the cycle, so no write lands beside it
  assign wr_live = wr_en && !soft_reset;
  // the offsets are exclusive, so at most one view is hit per cycle
  assign wr_hit_base = hit(addr, rapl_pkg::off_base, wr_live);
  assign wr_hit_set = hit(addr, rapl_pkg::off_set, wr_live);
  assign wr_hit_clear = hit(addr, rapl_pkg::off_clear, wr_live);
  assign wr_hit_toggle = hit(addr, rapl_pkg::off_toggle, wr_live);

  // ----------------------------------------
  // shared base/alias storage
  // ----------------------------------------
  rapl_store #(
    .width(data_w),
    .reset_value(rapl_pkg::base_reset)
  ) u_store (
    .clock(clock),
    .rstn(rstn),
    .soft_reset(soft_reset),
    .wr_base(wr_hit_base),
    .wr_set(wr_hit_set),
    .wr_clear(wr_hit_clear),
    .wr_toggle(wr_hit_toggle),
    .wdata(wdata),
    .value(store_value)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // reserved bits are masked off on store, so they never read back
  always_comb
  begin
    next_state = state;
    next_state.cmd = rapl_pkg::cmd_reset; // command bits are one-cycle strobes
    if (soft_reset)
    begin
      next_state.ctrl = rapl_pkg::ctrl_reset;
    end
    else if (wr_en)
    begin
      unique case (addr)
        rapl_pkg::off_ctrl:
        begin
          // reserved bits 7:6 are dropped, so a careless write cannot set them
          next_state.ctrl = keep(wdata, rapl_pkg::ctrl_mask);
        end
        rapl_pkg::off_cmd:
        begin
          // strobe bits live for one cycle only
          next_state.cmd = keep(wdata, rapl_pkg::cmd_mask);
        end
        rapl_pkg::off_debug:
        begin
          next_state.debug = keep(wdata, rapl_pkg::debug_mask);
        end
        default:
        begin
          // status is read-only and the base views go to the store
          next_state.ctrl = state.ctrl;
        end
      endcase
    end
    // read data are registered; write-only cmd reads zero, a legal undefined value
    next_state.rdata = rapl_pkg::zero;
    if (rd_en)
    begin
      unique case (addr)
        rapl_pkg::off_base, rapl_pkg::off_set,
        rapl_pkg::off_clear, rapl_pkg::off_toggle:
        begin
          // every view of the pair shows the one stored word
          next_state.rdata = store_value;
        end
        rapl_pkg::off_ctrl:
        begin
          next_state.rdata = keep(state.ctrl, rapl_pkg::ctrl_mask);
        end
        rapl_pkg::off_status:
        begin
          // live status, never shadowed by a write
          next_state.rdata = hw_status;
        end
        rapl_pkg::off_cmd:
        begin
          next_state.rdata = rapl_pkg::zero;
        end
        rapl_pkg::off_debug:
        begin
          next_state.rdata = keep(state.debug, rapl_pkg::debug_mask);
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // debug control is outside the soft reset on purpose
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state.ctrl <= rapl_pkg::ctrl_reset;
      state.debug <= rapl_pkg::debug_reset;
      state.cmd <= rapl_pkg::cmd_reset;
      state.rdata <= rapl_pkg::zero;
    end
    else
      state <= next_state;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = state.rdata;
  assign pair_value = store_value;
  assign mode = state.ctrl[rapl_pkg::mode_hi:rapl_pkg::mode_lo];
  assign cmd_pulse = state.cmd[3:0];
  assign debug_hold = state.debug[0];
endmodule

// ==== rapl_chk.sv ====
// checker of access and alias behaviour at the bank ports
`timescale 1ns/1ns
module rapl_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] hw_status,
  input wire logic [7:0] rdata,
  input wire logic [7:0] pair_value,
  input wire logic [3:0] mode,
  input wire logic [3:0] cmd_pulse,
  input wire logic debug_hold
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // soft reset wins over a write, so it is kept out of the write qualifier
  wire logic wq = wr_en && !soft_reset;
  set_bits_a: assert property (wq && addr == rapl_pkg::off_set
    |=> pair_value == ($past(pair_value) | $past(wdata))) else $error("set alias wrong");
  clear_bits_a: assert property (wq && addr == rapl_pkg::off_clear
    |=> pair_value == ($past(pair_value) & ~$past(wdata))) else $error("clear alias wrong");
  toggle_bits_a: assert property (wq && addr == rapl_pkg::off_toggle
    |=> pair_value == ($past(pair_value) ^ $past(wdata))) else $error("toggle alias wrong");
  pair_read_a: assert property (rd_en && addr <= rapl_pkg::off_toggle
    |=> rdata == $past(pair_value)) else $error("pair read differs");
  status_read_a: assert property (rd_en && addr == rapl_pkg::off_status
    |=> rdata == $past(hw_status)) else $error("status read wrong");
  ctrl_read_a: assert property (rd_en && addr == rapl_pkg::off_ctrl
    |=> rdata == {2'h0, $past(mode), 2'h0} || rdata[7:6] == 2'h0 && rdata[5:2] == $past(mode))
    else $error("ctrl read wrong");
  mode_field_a: assert property (wq && addr == rapl_pkg::off_ctrl
    |=> mode == $past(wdata[5:2])) else $error("mode field wrong");
  cmd_pulse_a: assert property (wq && addr == rapl_pkg::off_cmd
    |=> cmd_pulse == $past(wdata[3:0])) else $error("cmd pulse wrong");
  cmd_clear_a: assert property (!(wq && addr == rapl_pkg::off_cmd)
    |=> cmd_pulse == 4'h0) else $error("cmd pulse stayed");
  debug_write_a: assert property (wq && addr == rapl_pkg::off_debug
    |=> debug_hold == $past(wdata[0])) else $error("debug write wrong");
  soft_load_a: assert property (soft_reset |=> pair_value == rapl_pkg::base_reset
    && mode == 4'h0 && debug_hold == $past(debug_hold)) else $error("soft reset wrong");
endmodule
bind rapl_bank rapl_chk rapl_chk_inst (.clock, .rstn, .soft_reset, .addr, .wr_en, .rd_en, .wdata,
  .hw_status, .rdata, .pair_value, .mode, .cmd_pulse, .debug_hold);

// ==== rapl_pkg.sv ====
// package of constants for the register access pair logic
package rapl_pkg;
  localparam int unsigned data_w = 8;
  localparam int unsigned addr_w = 3;
  // register offsets within the peripheral window
  localparam logic [2:0] off_base = 3'h0;
  localparam logic [2:0] off_set = 3'h1;
  localparam logic [2:0] off_clear = 3'h2;
  localparam logic [2:0] off_toggle = 3'h3;
  localparam logic [2:0] off_ctrl = 3'h4;
  localparam logic [2:0] off_status = 3'h5;
  localparam logic [2:0] off_cmd = 3'h6;
  localparam logic [2:0] off_debug = 3'h7;
  // field masks and reset values: which bits exist, what reset loads
  localparam logic [7:0] base_reset = 8'h00;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] ctrl_mask = 8'h3F;
  localparam logic [7:0] debug_reset = 8'h00;
  localparam logic [7:0] debug_mask = 8'h01;
  localparam logic [7:0] cmd_mask = 8'h0F;
  localparam logic [7:0] cmd_reset = 8'h00;
  localparam logic [7:0] zero = 8'h00;
  // ctrl field [5:2] as high/low index
  localparam int unsigned mode_hi = 5;
  localparam int unsigned mode_lo = 2;
endpackage

// ==== rapl_store.sv ====
// one shared storage word with set, clear and toggle updates
`timescale 1ns/1ns
module rapl_store #(
  parameter int unsigned width = 8,
  parameter logic [7:0] reset_value = 8'h00
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic wr_base,
  input wire logic wr_set,
  input wire logic wr_clear,
  input wire logic wr_toggle,
  input wire logic [width-1:0] wdata,
  output logic [width-1:0] value
);
  typedef struct packed {
    logic [width-1:0] value;
  } rapl_store_s;

  rapl_store_s state;
  rapl_store_s next_state;

  initial
  begin
    if (width < 1 || width > 8)
      $error("rapl_store width out of range");
  end

  // only the one bits of an alias write touch storage
  always_comb
  begin
    next_state = state;
    if (soft_reset)
      next_state.value = reset_value[width-1:0];
    else if (wr_base)
      next_state.value = wdata;
    else if (wr_set)
      next_state.value = state.value | wdata;
    else if (wr_clear)
      next_state.value = state.value & ~wdata;
    else if (wr_toggle)
      next_state.value = state.value ^ wdata;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state <= '{value: reset_value[width-1:0]};
    else
      state <= next_state;
  end

  assign value = state.value;
endmodule

// ==== tb_top.sv ====
// self-checking bench for the register bank
`timescale 1ns/1ns
module tb_top;
  logic clock = 0, rstn = 0, soft_reset = 0, wr_en = 0, rd_en = 0, debug_hold;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, hw_status = 8'h00, rdata, pair_value;
  logic [3:0] mode, cmd_pulse;
  int bad_count = 0, n_compared = 0, cyc = 0;
  rapl_bank rapl_bank_inst (.clock, .rstn, .soft_reset, .addr, .wr_en, .rd_en, .wdata,
    .hw_status, .rdata, .pair_value, .mode, .cmd_pulse, .debug_hold);
  // ------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------
  initial forever #4 clock = ~clock;
  // a hung run counts as a mismatch
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // the trailing #1 lets the taking edge land before callers look
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task t_alias;
    wr(rapl_pkg::off_base, 8'h0F);
    wr(rapl_pkg::off_set, 8'hF0);
    rd(rapl_pkg::off_base, 8'hFF);
    wr(rapl_pkg::off_clear, 8'h3C);
    rd(rapl_pkg::off_set, 8'hC3);
    wr(rapl_pkg::off_toggle, 8'hFF);
    rd(rapl_pkg::off_clear, 8'h3C);
    rd(rapl_pkg::off_toggle, 8'h3C);
  endtask
  task t_access;
    @(posedge clock);
    hw_status <= 8'hA5;
    wr(rapl_pkg::off_status, 8'hFF);
    rd(rapl_pkg::off_status, 8'hA5);
    wr(rapl_pkg::off_ctrl, 8'h14);
    chk("mode", {4'h0, mode}, 8'h05);
    wr(rapl_pkg::off_ctrl, 8'hFF);
    chk("mode", {4'h0, mode}, 8'h0F);
    rd(rapl_pkg::off_ctrl, 8'h3F);
    wr(rapl_pkg::off_cmd, 8'hFA);
    chk("cmd_pulse", {4'h0, cmd_pulse}, 8'h0A);
    rd(rapl_pkg::off_cmd, 8'h00);
    wr(rapl_pkg::off_debug, 8'hFF);
    rd(rapl_pkg::off_debug, 8'h01);
  endtask
  task t_soft;
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    #1 chk("pair_value", pair_value, 8'h00);
    chk("debug_hold", {7'h00, debug_hold}, 8'h01);
    rd(rapl_pkg::off_ctrl, 8'h00);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence after a 20 cycle reset
  initial
  begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    #1 chk("pair_value", pair_value, 8'h00);
    chk("rdata", rdata, 8'h00);
    chk("mode", {4'h0, mode}, 8'h00);
    t_alias();
    t_access();
    t_soft();
    complete_run();
  end
endmodule
